// *** reference_setpoint_ramp_control_test.sv ***
// testbench: random and corner stimulus for the ramp control block
`timescale 1ns/1ps
module reference_setpoint_ramp_control_test;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic run_i = 1'b1;
  logic slew_tick_i = 1'b0;
  logic sync_clk_present_i = 1'b0;
  logic mode_pin_gnd_i = 1'b1;
  logic mode_pin_vcc_i = 1'b0;
  logic fb_over_110_i = 1'b0;
  wire logic [3:0] reg_addr_i;
  wire logic [15:0] reg_wdata_i;
  wire logic reg_wr_i;
  wire logic reg_rd_i;
  wire logic [15:0] reg_rdata_o;
  wire logic [8:0] dac_code_o;
  wire logic ramp_active_o;
  wire logic [1:0] light_load_mode_o;
  wire logic top_gate_drives_o;
  wire logic overvoltage_o;
  wire logic loop_on_o;
  logic [2:0] tdiv = 3'h0;
  logic [8:0] nom;
  logic [8:0] hi;
  logic [8:0] lo;
  logic [15:0] rv;
  int ntick = 0;
  int failures = 0;
  int compares = 0;
  int seed = 21965;
  int t0;
  int d;
  // ********
  // clock, slew ticks, instances
  // ********
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    tdiv <= tdiv + 3'h1;
    slew_tick_i <= tdiv[2];
    if (tdiv == 3'h4) ntick <= ntick + 1;
  end
  rsr_ramp_ctrl dut (.clk_sys_i, .rst_i, .run_i, .slew_tick_i, .sync_clk_present_i, .mode_pin_gnd_i,
    .mode_pin_vcc_i, .fb_over_110_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .dac_code_o, .ramp_active_o, .light_load_mode_o, .top_gate_drives_o, .overvoltage_o, .loop_on_o);
  rsr_host_model host (.clk_sys_i, .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
  // ********
  // expectations and helpers
  // ********
  function automatic logic [8:0] target(input logic [1:0] m);
    target = (m == rsr_pkg::MARGIN_LOW) ? lo : (m == rsr_pkg::MARGIN_HIGH) ? hi : nom;
  endfunction
  function automatic int slew_div(input logic [1:0] s);
    slew_div = (s == rsr_pkg::SLEW_FAST) ? 1 : (s == rsr_pkg::SLEW_SLOW) ? 16 : 2;
  endfunction
  function automatic logic [1:0] exp_mode(input int i);
    exp_mode = (i == 0) ? rsr_pkg::MODE_BURST : (i == 1) ? rsr_pkg::MODE_SKIP : rsr_pkg::MODE_FCM;
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle();
    int n;
    n = 0;
    @(posedge clk_sys_i);
    while (ramp_active_o !== 1'b0 && n < 4000) begin
      @(posedge clk_sys_i);
      n++;
    end
    check("ramp settled", {15'h0000, ramp_active_o}, 16'h0000);
  endtask
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    conclude();
  end
  // ********
  // scenarios
  // ********
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    for (int a = 0; a < 9; a++) begin
      if (a != 5 && a != 6) begin
        host.rd(a[3:0], rv);
        check("reset read", rv, 16'h0000);
      end
    end
    nom = 9'h000;
    for (int s = 0; s < 3; s++) begin
      d = 3 + ($unsigned($random(seed)) % 6);
      nom = nom + d[8:0];
      host.wr(rsr_pkg::ADDR_MFR_CFG, {14'h0000, s[1:0]});
      t0 = ntick;
      host.wr(rsr_pkg::ADDR_NOMINAL, {7'h00, nom});
      repeat (2) @(posedge clk_sys_i);
      check("ramp mode", {14'h0000, light_load_mode_o}, {14'h0000, rsr_pkg::MODE_FCM});
      settle();
      check("dac code", {7'h00, dac_code_o}, {7'h00, nom});
      t0 = ntick - t0 - d * slew_div(s[1:0]);
      check("step rate", {15'h0000, t0 >= -1 && t0 <= 1}, 16'h0001);
      host.rd(rsr_pkg::ADDR_NOMINAL, rv);
      check("nominal reg", rv, {7'h00, nom});
    end
    rv = $random(seed);
    hi = {3'h0, rv[5:0]};
    lo = {3'h0, rv[11:6]};
    host.wr(rsr_pkg::ADDR_MFR_CFG, {14'h0000, rsr_pkg::SLEW_FAST});
    host.wr(rsr_pkg::ADDR_MARGIN_HI, {7'h00, hi});
    host.wr(rsr_pkg::ADDR_MARGIN_LO, {7'h00, lo});
    for (int m = 3; m >= 0; m--) begin
      host.wr(rsr_pkg::ADDR_OPERATION, {8'h00, 2'h2, m[1:0], 4'h0});
      settle();
      check("margin target", {7'h00, dac_code_o}, {7'h00, target(m[1:0])});
    end
    check("loop on", {15'h0000, loop_on_o}, 16'h0001);
    host.wr(rsr_pkg::ADDR_SOFT_RESET, 16'h00a5);
    for (int a = 0; a < 3; a++) begin
      host.rd(a[3:0], rv);
      check("soft reset clear", rv, 16'h0000);
    end
    host.wr(rsr_pkg::ADDR_NOMINAL, 16'h0011);
    settle();
    run_i <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    run_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    check("loop off after run", {15'h0000, loop_on_o}, 16'h0000);
    host.rd(rsr_pkg::ADDR_NOMINAL, rv);
    check("run clear", rv, 16'h0000);
    settle();
    for (int i = 0; i < 4; i++) begin
      sync_clk_present_i <= (i == 3);
      mode_pin_gnd_i <= (i == 0 || i == 3);
      mode_pin_vcc_i <= (i == 2);
      repeat (12) @(posedge clk_sys_i);
      check("light load mode", {14'h0000, light_load_mode_o}, {14'h0000, exp_mode(i)});
      host.rd(rsr_pkg::ADDR_STATUS, rv);
      check("status", rv, {11'h000, 1'b0, exp_mode(i), 2'h2});
      @(posedge clk_sys_i);
    end
    fb_over_110_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    check("gates on", {14'h0000, top_gate_drives_o, overvoltage_o}, 16'h0003);
    fb_over_110_i <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    check("gates off", {14'h0000, top_gate_drives_o, overvoltage_o}, 16'h0000);
    conclude();
  end
endmodule

// *** rsr_host_model.sv ***
// partner: host issuing setpoint and margin commands
`timescale 1ns/1ps
module rsr_host_model (
  input wire logic clk_sys_i,
  input wire logic [15:0] reg_rdata_i,
  output logic [3:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  // ********
  // command cycles
  // ********
  initial begin
    reg_addr_o = 4'h0;
    reg_wdata_o = 16'h0000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    @(negedge clk_sys_i);
    d = reg_rdata_i;
  endtask
endmodule

// *** rsr_pkg.sv ***
// package: constants for the reference setpoint ramp block
package rsr_pkg;
  // ************************************************************
  // register map (word offsets)
  // ************************************************************
  localparam logic [3:0] ADDR_NOMINAL = 4'h0;
  localparam logic [3:0] ADDR_MARGIN_HI = 4'h1;
  localparam logic [3:0] ADDR_MARGIN_LO = 4'h2;
  localparam logic [3:0] ADDR_OPERATION = 4'h3;
  localparam logic [3:0] ADDR_MFR_CFG = 4'h4;
  localparam logic [3:0] ADDR_SOFT_RESET = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_DAC_CODE = 4'h7;
  // ************************************************************
  // field positions and values
  // ************************************************************
  localparam int OP_ON_BIT = 7;
  localparam int OP_MARGIN_LSB = 4;
  localparam logic [1:0] MARGIN_NOM = 2'h0;
  localparam logic [1:0] MARGIN_LOW = 2'h1;
  localparam logic [1:0] MARGIN_HIGH = 2'h2;
  localparam logic [1:0] SLEW_NOM = 2'h0;
  localparam logic [1:0] SLEW_FAST = 2'h1;
  localparam logic [1:0] SLEW_SLOW = 2'h2;
  localparam logic [8:0] CODE_RESET = 9'h000;
  localparam logic [7:0] OP_RESET = 8'h00;
  localparam logic [1:0] CFG_RESET = 2'h0;
  // ************************************************************
  // light-load mode encodings
  // ************************************************************
  localparam logic [1:0] MODE_BURST = 2'h0;
  localparam logic [1:0] MODE_SKIP = 2'h1;
  localparam logic [1:0] MODE_FCM = 2'h2;
  // ************************************************************
  // timing: step tick counts in slew ticks (slow rate is SLOW_DIV times NOM_DIV)
  // ************************************************************
  localparam logic [3:0] SLOW_DIV = 4'h8;
  localparam logic [3:0] NOM_DIV = 4'h2;
  localparam logic [3:0] FAST_DIV = 4'h1;
  typedef enum logic [1:0] {RSR_IDLE, RSR_UP, RSR_DOWN} rsr_state_t;
endpackage

// *** rsr_ramp_ctrl.sv ***
// module: reference setpoint ramp control
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module rsr_ramp_ctrl (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic slew_tick_i,
  input wire logic sync_clk_present_i,
  input wire logic mode_pin_gnd_i,
  input wire logic mode_pin_vcc_i,
  input wire logic fb_over_110_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic [8:0] dac_code_o,
  output logic ramp_active_o,
  output logic [1:0] light_load_mode_o,
  output logic top_gate_drives_o,
  output logic overvoltage_o,
  output logic loop_on_o
);
  // ************************************************************
  // pin input synchronisers
  // ************************************************************
  logic [2:0] run_s;
  logic [2:0] tick_s;
  logic [2:0] sync_s;
  logic [2:0] gnd_s;
  logic [2:0] vcc_s;
  logic [2:0] ov_s;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      run_s <= 3'h0;
      tick_s <= 3'h0;
      sync_s <= 3'h0;
      gnd_s <= 3'h0;
      vcc_s <= 3'h0;
      ov_s <= 3'h0;
    end else begin
      run_s <= {run_s[1:0], run_i};
      tick_s <= {tick_s[1:0], slew_tick_i};
      sync_s <= {sync_s[1:0], sync_clk_present_i};
      gnd_s <= {gnd_s[1:0], mode_pin_gnd_i};
      vcc_s <= {vcc_s[1:0], mode_pin_vcc_i};
      ov_s <= {ov_s[1:0], fb_over_110_i};
    end
  end
  // ************************************************************
  // filtered levels: change counts once stages two and three agree
  // ************************************************************
  logic run_f;
  logic tick_f;
  logic sync_f;
  logic gnd_f;
  logic vcc_f;
  logic ov_f;
  logic next_run_f;
  logic next_tick_f;
  logic next_sync_f;
  logic next_gnd_f;
  logic next_vcc_f;
  logic next_ov_f;
  always_comb begin
    next_run_f = (run_s[1] == run_s[2]) ? run_s[2] : run_f;
    next_tick_f = (tick_s[1] == tick_s[2]) ? tick_s[2] : tick_f;
    next_sync_f = (sync_s[1] == sync_s[2]) ? sync_s[2] : sync_f;
    next_gnd_f = (gnd_s[1] == gnd_s[2]) ? gnd_s[2] : gnd_f;
    next_vcc_f = (vcc_s[1] == vcc_s[2]) ? vcc_s[2] : vcc_f;
    next_ov_f = (ov_s[1] == ov_s[2]) ? ov_s[2] : ov_f;
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      run_f <= 1'b0;
      tick_f <= 1'b0;
      sync_f <= 1'b0;
      gnd_f <= 1'b0;
      vcc_f <= 1'b0;
      ov_f <= 1'b0;
    end else begin
      run_f <= next_run_f;
      tick_f <= next_tick_f;
      sync_f <= next_sync_f;
      gnd_f <= next_gnd_f;
      vcc_f <= next_vcc_f;
      ov_f <= next_ov_f;
    end
  end
  // ************************************************************
  // edge detect
  // ************************************************************
  logic run_rise;
  logic tick_rise;
  assign run_rise = next_run_f & ~run_f;
  assign tick_rise = next_tick_f & ~tick_f;
  // ************************************************************
  // register file
  // ************************************************************
  logic [8:0] nominal_setpoint_cmd;
  logic [8:0] upper_margin_setpoint;
  logic [8:0] lower_margin_setpoint;
  logic [7:0] operation;
  logic [1:0] manufacturer_settings_cmd;
  logic [8:0] next_nominal;
  logic [8:0] next_hi;
  logic [8:0] next_lo;
  logic [7:0] next_operation;
  logic [1:0] next_cfg;
  logic clear_codes;
  assign clear_codes = run_rise | (reg_wr_i && reg_addr_i == rsr_pkg::ADDR_SOFT_RESET);
  always_comb begin
    next_nominal = nominal_setpoint_cmd;
    next_hi = upper_margin_setpoint;
    next_lo = lower_margin_setpoint;
    next_operation = operation;
    next_cfg = manufacturer_settings_cmd;
    if (reg_wr_i) begin
      case (reg_addr_i)
        rsr_pkg::ADDR_NOMINAL: next_nominal = reg_wdata_i[8:0];
        rsr_pkg::ADDR_MARGIN_HI: next_hi = reg_wdata_i[8:0];
        rsr_pkg::ADDR_MARGIN_LO: next_lo = reg_wdata_i[8:0];
        rsr_pkg::ADDR_OPERATION: next_operation = reg_wdata_i[7:0];
        rsr_pkg::ADDR_MFR_CFG: next_cfg = reg_wdata_i[1:0];
        default: ;
      endcase
    end
    if (clear_codes) begin
      next_nominal = rsr_pkg::CODE_RESET;
      next_hi = rsr_pkg::CODE_RESET;
      next_lo = rsr_pkg::CODE_RESET;
    end
    if (run_rise) begin
      next_operation[rsr_pkg::OP_ON_BIT] = 1'b0;
    end
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      nominal_setpoint_cmd <= rsr_pkg::CODE_RESET;
      upper_margin_setpoint <= rsr_pkg::CODE_RESET;
      lower_margin_setpoint <= rsr_pkg::CODE_RESET;
      operation <= rsr_pkg::OP_RESET;
      manufacturer_settings_cmd <= rsr_pkg::CFG_RESET;
    end else begin
      nominal_setpoint_cmd <= next_nominal;
      upper_margin_setpoint <= next_hi;
      lower_margin_setpoint <= next_lo;
      operation <= next_operation;
      manufacturer_settings_cmd <= next_cfg;
    end
  end
  // ************************************************************
  // target select
  // ************************************************************
  logic [8:0] target;
  logic [1:0] margin_sel;
  assign margin_sel = operation[rsr_pkg::OP_MARGIN_LSB +: 2];
  always_comb begin
    case (margin_sel)
      rsr_pkg::MARGIN_HIGH: target = upper_margin_setpoint;
      rsr_pkg::MARGIN_LOW: target = lower_margin_setpoint;
      default: target = nominal_setpoint_cmd;
    endcase
  end
  // ************************************************************
  // step rate divider: ticks from the slew timing capacitor
  // ************************************************************
  logic [4:0] tick_cnt;
  logic [4:0] next_tick_cnt;
  logic [4:0] step_div;
  logic step_en;
  always_comb begin
    case (manufacturer_settings_cmd)
      rsr_pkg::SLEW_FAST: step_div = {1'b0, rsr_pkg::FAST_DIV};
      rsr_pkg::SLEW_SLOW: step_div = 5'(rsr_pkg::SLOW_DIV) * 5'(rsr_pkg::NOM_DIV);
      default: step_div = {1'b0, rsr_pkg::NOM_DIV};
    endcase
  end
  always_comb begin
    step_en = 1'b0;
    next_tick_cnt = tick_cnt;
    if (!ramp_active_o) begin
      next_tick_cnt = 5'h00;
    end else if (tick_rise) begin
      if (tick_cnt + 5'h01 >= step_div) begin
        step_en = 1'b1;
        next_tick_cnt = 5'h00;
      end else begin
        next_tick_cnt = tick_cnt + 5'h01;
      end
    end
  end
  // ************************************************************
  // ramp state machine
  // ************************************************************
  rsr_pkg::rsr_state_t ramp_dir;
  logic [8:0] next_dac;
  always_comb begin
    next_dac = dac_code_o;
    if (target > dac_code_o) begin
      ramp_dir = rsr_pkg::RSR_UP;
    end else if (target < dac_code_o) begin
      ramp_dir = rsr_pkg::RSR_DOWN;
    end else begin
      ramp_dir = rsr_pkg::RSR_IDLE;
    end
    case (ramp_dir)
      rsr_pkg::RSR_UP: if (step_en) next_dac = dac_code_o + 9'h001;
      rsr_pkg::RSR_DOWN: if (step_en) next_dac = dac_code_o - 9'h001;
      default: ;
    endcase
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dac_code_o <= rsr_pkg::CODE_RESET;
      tick_cnt <= 5'h00;
    end else begin
      dac_code_o <= next_dac;
      tick_cnt <= next_tick_cnt;
    end
  end
  assign ramp_active_o = (dac_code_o != target);
  // ************************************************************
  // light-load mode and protection
  // ************************************************************
  logic [1:0] pin_mode;
  always_comb begin
    if (vcc_f) begin
      pin_mode = rsr_pkg::MODE_FCM;
    end else if (gnd_f) begin
      pin_mode = rsr_pkg::MODE_BURST;
    end else begin
      pin_mode = rsr_pkg::MODE_SKIP;
    end
  end
  logic [1:0] next_mode;
  logic next_gate;
  always_comb begin
    next_mode = pin_mode;
    if (sync_f) next_mode = rsr_pkg::MODE_FCM;
    if (ramp_active_o) next_mode = rsr_pkg::MODE_FCM;
    next_gate = ov_f;
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      light_load_mode_o <= rsr_pkg::MODE_BURST;
      top_gate_drives_o <= 1'b0;
      overvoltage_o <= 1'b0;
    end else begin
      light_load_mode_o <= next_mode;
      top_gate_drives_o <= next_gate;
      overvoltage_o <= next_gate;
    end
  end
  // ************************************************************
  // loop enable
  // ************************************************************
  assign loop_on_o = operation[rsr_pkg::OP_ON_BIT] & run_f;
  // ************************************************************
  // read port
  // ************************************************************
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        rsr_pkg::ADDR_NOMINAL: next_rdata = {7'h00, nominal_setpoint_cmd};
        rsr_pkg::ADDR_MARGIN_HI: next_rdata = {7'h00, upper_margin_setpoint};
        rsr_pkg::ADDR_MARGIN_LO: next_rdata = {7'h00, lower_margin_setpoint};
        rsr_pkg::ADDR_OPERATION: next_rdata = {8'h00, operation};
        rsr_pkg::ADDR_MFR_CFG: next_rdata = {14'h0000, manufacturer_settings_cmd};
        rsr_pkg::ADDR_STATUS: next_rdata = {11'h000, overvoltage_o, light_load_mode_o, run_f, ramp_active_o};
        rsr_pkg::ADDR_DAC_CODE: next_rdata = {7'h00, dac_code_o};
        default: next_rdata = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end
endmodule

// *** rsr_ramp_ctrl_props.sv ***
// checker: port assertions for the ramp control block
`timescale 1ns/1ps
module rsr_ramp_ctrl_props (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic sync_clk_present_i,
  input wire logic fb_over_110_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [8:0] dac_code_o,
  input wire logic ramp_active_o,
  input wire logic [1:0] light_load_mode_o,
  input wire logic top_gate_drives_o,
  input wire logic overvoltage_o,
  input wire logic loop_on_o
);
  // ********
  // properties
  // ********
  default clocking dcb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_gates_held_on: assert property (fb_over_110_i [*8] |-> top_gate_drives_o)
    else $error("top gates not held on");
  a_gates_released: assert property (!fb_over_110_i [*8] |-> !top_gate_drives_o)
    else $error("top gates held without overvoltage");
  a_ov_flag_pair: assert property (overvoltage_o == top_gate_drives_o)
    else $error("overvoltage flag apart from gates");
  a_step_one_lsb: assert property (!$stable(dac_code_o) |->
    dac_code_o == $past(dac_code_o) + 9'h001 || dac_code_o == $past(dac_code_o) - 9'h001)
    else $error("dac moved by more than one lsb");
  a_step_needs_ramp: assert property (!$stable(dac_code_o) |-> $past(ramp_active_o))
    else $error("dac moved while at target");
  a_ramp_forces_fcm: assert property (ramp_active_o [*3] |-> light_load_mode_o == rsr_pkg::MODE_FCM)
    else $error("ramp without forced-continuous");
  a_sync_forces_fcm: assert property (sync_clk_present_i [*8] |-> light_load_mode_o == rsr_pkg::MODE_FCM)
    else $error("sync without forced-continuous");
  a_dac_readback: assert property (reg_rd_i && reg_addr_i == rsr_pkg::ADDR_DAC_CODE
    |=> reg_rdata_o == {7'h00, $past(dac_code_o)})
    else $error("dac readback wrong");
  a_run_low_off: assert property (!run_i [*8] |-> !loop_on_o)
    else $error("loop on with run low");
  c_ramp: cover property (ramp_active_o [*3]);
  c_ov: cover property (fb_over_110_i [*8] ##0 top_gate_drives_o);
  c_sync: cover property (sync_clk_present_i [*8]);
endmodule
bind rsr_ramp_ctrl rsr_ramp_ctrl_props u_props (.clk_sys_i, .rst_i, .run_i, .sync_clk_present_i, .fb_over_110_i,
  .reg_addr_i, .reg_rd_i, .reg_rdata_o, .dac_code_o, .ramp_active_o, .light_load_mode_o, .top_gate_drives_o,
  .overvoltage_o, .loop_on_o);
